//--- hw/svwd_params.svh
// timing counts, counter width and ratio multipliers for the supervisor watchdog block
`ifndef SVWD_PARAMS_SVH
`define SVWD_PARAMS_SVH

// ****************************************************************
// counter sizing and multipliers
// ****************************************************************
`define SVWD_CNT_W 32
`define SVWD_EXT_MULT 128
`define SVWD_RATIO_A 8
`define SVWD_RATIO_B 16
`define SVWD_RATIO_C 64

// ****************************************************************
// default cycle counts at 125 MHz (8 ns period)
// ****************************************************************
`define SVWD_CLK_NS 8
`define SVWD_RST_HOLD_NS 200000000
`define SVWD_RST_HOLD_CYC (`SVWD_RST_HOLD_NS / `SVWD_CLK_NS)
`define SVWD_WD_BASE_NS 100000000
`define SVWD_WD_BASE_CYC (`SVWD_WD_BASE_NS / `SVWD_CLK_NS)
`define SVWD_SLOW_NS 975000000
`define SVWD_SLOW_CYC (`SVWD_SLOW_NS / `SVWD_CLK_NS)

`endif

//--- hw/svwd_pkg.sv
// types shared by the supervisor watchdog block
package svwd_pkg;
	typedef enum logic [1:0] {
		SVWD_RST_ACTIVE,
		SVWD_RST_HOLD,
		SVWD_RUN
	} svwd_state_type;
endpackage

//--- hw/svwd_sync.sv
// two-flop synchroniser bank for asynchronous input pins
`timescale 1ns/1ns
module svwd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// pins in, synchronised out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// one generate per bit so each bit is its own two-stage chain
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk) begin
			if (reset) begin
				meta_ff[i] <= INIT[i];
				sync_ff[i] <= INIT[i];
			end else begin
				meta_ff[i] <= asyncIn[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

	assign syncOut = sync_ff;
endmodule

//--- hw/svwd_top.sv
// supervisor: reset generator with single-timeout or windowed watchdog
//
// Operation
// RULE1: reset output low while supply low, monitored level low, or manual low.
// RULE2: after all causes clear, hold reset low one full timeout, then release.
// RULE3: any watchdog fault gives a reset pulse of exactly the timeout.
// RULE4: single variant: mode low normal, mode high period times 128.
// RULE5: single variant: mode input change clears the watchdog timer.
// RULE6: processor must kick with a falling edge within the period.
// RULE7: single variant: kick transition or asserted reset clears the timer.
// RULE8: single variant: zero period setting disables the watchdog.
// RULE9: windowed: kick interval below fast or above slow limit faults.
// RULE10: windowed: timer starts counting only after reset release.
// RULE11: windowed: valid kick clears and restarts; reset holds it cleared.
// RULE12: windowed: strap lo high and hi low disables the watchdog.
// RULE13: fast limit is slow limit over 8, 16 or 64 by straps.
// RULE14: windowed: kick edges ignored while reset is asserted.
// RULE15: windowed: any ratio strap change clears the watchdog timer.
// RULE16: timeout, basic period and slow limit are cycle-count inputs.
`timescale 1ns/1ns
`include "svwd_params.svh"
module svwd_top
	import svwd_pkg::*;
#(
	parameter bit WINDOWED = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// reset causes, comparator results from the analog side
	input wire logic supplyLow,
	input wire logic monLevelLow,
	input wire logic manual_rst_n,
	// watchdog pins
	input wire logic wd_kick_in,
	input wire logic wd_mode_select,
	input wire logic window_ratio_sel_lo,
	input wire logic window_ratio_sel_hi,
	// period settings in clock cycles, quasi-static
	input wire logic [`SVWD_CNT_W-1:0] rst_period_setting,
	input wire logic [`SVWD_CNT_W-1:0] wd_period_setting,
	// outputs
	output logic rst_n,
	output logic wdFault
);
	localparam int W = `SVWD_CNT_W;

	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	// supply-low cause starts out present so nothing releases before the chain fills
	logic [4:0] pinSync;
	svwd_sync #(.WIDTH(5), .INIT(5'h1c)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.asyncIn({manual_rst_n, wd_kick_in, supplyLow, monLevelLow,
			wd_mode_select}),
		.syncOut(pinSync)
	);
	// ratio straps synchronised on their own so each keeps its meaning
	logic [1:0] strapSync;
	svwd_sync #(.WIDTH(2), .INIT(2'h0)) u_strap (
		.mclk(mclk),
		.reset(reset),
		.asyncIn({window_ratio_sel_hi, window_ratio_sel_lo}),
		.syncOut(strapSync)
	);

	logic mrN;
	logic kick;
	logic vLow;
	logic mLow;
	logic modeSel;
	assign mrN = pinSync[4];
	assign kick = pinSync[3];
	assign vLow = pinSync[2];
	assign mLow = pinSync[1];
	assign modeSel = pinSync[0];

	// ****************************************************************
	// history for edge and change detection
	// ****************************************************************
	logic kick_ff;
	logic mode_ff;
	logic [1:0] strap_ff;
	always_ff @(posedge mclk) begin
		if (reset) begin
			kick_ff <= 1'b1;
			mode_ff <= 1'b0;
			strap_ff <= 2'h0;
		end else begin
			kick_ff <= kick;
			mode_ff <= modeSel;
			strap_ff <= strapSync;
		end
	end

	logic kickFall;
	logic kickAny;
	logic modeChg;
	logic strapChg;
	assign kickFall = kick_ff & ~kick;
	assign kickAny = kick_ff ^ kick;
	assign modeChg = mode_ff ^ modeSel;
	assign strapChg = |(strap_ff ^ strapSync);

	// ****************************************************************
	// reset generator
	// ****************************************************************
	svwd_state_type state_ff;
	svwd_state_type nxt_state;
	logic [W-1:0] hold_ff;
	logic fault;
	logic cause;
	assign cause = vLow | mLow | ~mrN; // RULE1

	// causes dominate; a fault starts a fresh timeout from the run state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SVWD_RST_ACTIVE: begin
				if (!cause) begin
					nxt_state = SVWD_RST_HOLD;
				end
			end
			SVWD_RST_HOLD: begin
				if (cause) begin
					nxt_state = SVWD_RST_ACTIVE;
				end else if (hold_ff + 32'h1 >= rst_period_setting) begin
					nxt_state = SVWD_RUN; // RULE2
				end
			end
			SVWD_RUN: begin
				if (cause) begin
					nxt_state = SVWD_RST_ACTIVE; // RULE1
				end else if (fault) begin
					nxt_state = SVWD_RST_HOLD; // RULE3
				end
			end
			default: nxt_state = SVWD_RST_ACTIVE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff <= SVWD_RST_ACTIVE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// hold counter runs only in the hold state, so the pulse is one timeout
	always_ff @(posedge mclk) begin
		if (reset || state_ff != SVWD_RST_HOLD) begin
			hold_ff <= '0;
		end else begin
			hold_ff <= hold_ff + 32'h1; // RULE2 RULE3 RULE16
		end
	end

	logic rstN_ff;
	always_ff @(posedge mclk) begin
		if (reset) begin
			rstN_ff <= 1'b0;
		end else begin
			rstN_ff <= (nxt_state == SVWD_RUN);
		end
	end
	assign rst_n = rstN_ff;

	// ****************************************************************
	// watchdog timer
	// ****************************************************************
	logic running;
	assign running = (state_ff == SVWD_RUN) && rstN_ff; // RULE10 RULE14

	// single variant period: extended mode multiplies by 128; 40-bit math
	// avoids overflow, limit saturated to the counter width
	logic [W+7:0] limitWide;
	logic [W-1:0] slowLimit;
	logic [W-1:0] fastLimit;
	logic wdDisabled;
	always_comb begin
		limitWide = {8'h0, wd_period_setting};
		if (modeSel) begin
			limitWide = {1'b0, wd_period_setting, 7'h0}; // RULE4
		end
		slowLimit = (|limitWide[W+7:W]) ? '1 : limitWide[W-1:0];
		case (strapSync)
			2'b00: fastLimit = wd_period_setting >> 3; // RULE13
			2'b10: fastLimit = wd_period_setting >> 4; // RULE13
			2'b11: fastLimit = wd_period_setting >> 6; // RULE13
			default: fastLimit = '0;
		endcase
		if (WINDOWED) begin
			slowLimit = wd_period_setting; // RULE16
			wdDisabled = (strapSync == 2'b01); // RULE12
		end else begin
			wdDisabled = (wd_period_setting == '0); // RULE8
		end
	end

	logic clearTmr;
	assign clearTmr = WINDOWED ? (strapChg | kickFall) // RULE15 RULE11
		: (modeChg | kickAny); // RULE5 RULE7

	logic [W-1:0] wd_ff;
	// timer held at zero whenever reset is out or the watchdog is off
	always_ff @(posedge mclk) begin
		if (reset || !running || wdDisabled || clearTmr) begin
			wd_ff <= '0; // RULE7 RULE11
		end else if (wd_ff != '1) begin
			wd_ff <= wd_ff + 32'h1;
		end
	end

	// fault decode: windowed checks a kick arriving too early, both check
	// the timer reaching the slow limit; RULE6 is the processor's side
	always_comb begin
		fault = 1'b0;
		if (running && !wdDisabled) begin
			if (wd_ff + 32'h1 >= slowLimit && !(WINDOWED && kickFall)) begin
				fault = 1'b1; // RULE6 RULE9
			end
			if (WINDOWED && kickFall && !strapChg && wd_ff < fastLimit) begin
				fault = 1'b1; // RULE9
			end
		end
	end

	logic fault_ff;
	always_ff @(posedge mclk) begin
		if (reset) begin
			fault_ff <= 1'b0;
		end else begin
			fault_ff <= fault && !cause;
		end
	end
	assign wdFault = fault_ff;
endmodule

//--- test/svwd_cpu_model.sv
// processor model that kicks the watchdog
`timescale 1ns/1ns
module svwd_cpu_model (
	// clock and reset from the supervisor
	input wire logic mclk,
	input wire logic rstN,
	// kick spacing in cycles, zero for a hung processor
	input wire logic [15:0] gap,
	// kick pin
	output logic kick = 1'b0
);
	logic [15:0] cnt = 16'h0;
	// restarts its loop on reset, so the first fall is a full gap late
	always @(negedge mclk) begin
		cnt <= (rstN !== 1'b1 || cnt + 16'h1 >= gap) ? 16'h0 : cnt + 16'h1;
		kick <= (gap != 16'h0) && (cnt >= gap / 2);
	end
endmodule

//--- test/svwd_top_assertions.sv
// port assertions for the supervisor watchdog
`timescale 1ns/1ns
`include "svwd_params.svh"
module svwd_top_assertions #(
	parameter bit WINDOWED = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// pins
	input wire logic supplyLow,
	input wire logic monLevelLow,
	input wire logic manual_rst_n,
	input wire logic wd_kick_in,
	input wire logic wd_mode_select,
	input wire logic window_ratio_sel_lo,
	input wire logic window_ratio_sel_hi,
	input wire logic [`SVWD_CNT_W-1:0] rst_period_setting,
	input wire logic [`SVWD_CNT_W-1:0] wd_period_setting,
	// outputs
	input wire logic rst_n,
	input wire logic wdFault
);
	logic [31:0] lowCnt_ff;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);
	// length of the current low phase, read at release
	always_ff @(posedge mclk) begin
		lowCnt_ff <= (reset || rst_n) ? '0 : lowCnt_ff + 32'h1;
	end
	supply_low_a: assert property (supplyLow [*6] |-> !rst_n)
		else $error("supply");
	monitor_low_a: assert property (monLevelLow [*6] |-> !rst_n)
		else $error("monitor");
	manual_low_a: assert property (!manual_rst_n [*6] |-> !rst_n)
		else $error("manual");
	release_hold_a: assert property (
		$rose(rst_n) |-> lowCnt_ff >= rst_period_setting) else $error("hold");
	fault_pulse_a: assert property (wdFault |=> !wdFault)
		else $error("pulse");
	fault_rst_a: assert property (wdFault |-> !rst_n)
		else $error("fault reset");
	fault_hold_a: assert property (
		wdFault && rst_period_setting >= 32'h9 |=> !rst_n [*8])
		else $error("fault hold");
	fault_armed_a: assert property (wdFault |-> $past(rst_n))
		else $error("armed");
	single_off_a: assert property (!WINDOWED && wd_period_setting == '0 &&
		$past(wd_period_setting) == '0 |-> !wdFault) else $error("off");
	window_off_a: assert property ((WINDOWED && window_ratio_sel_lo &&
		!window_ratio_sel_hi) [*5] |-> !wdFault) else $error("win off");
	cover property (wdFault);
	cover property ($rose(rst_n));
	cover property (!manual_rst_n);
endmodule
bind svwd_top svwd_top_assertions #(.WINDOWED(WINDOWED)) u_chk (
	.mclk(mclk), .reset(reset), .supplyLow(supplyLow),
	.monLevelLow(monLevelLow), .manual_rst_n(manual_rst_n),
	.wd_kick_in(wd_kick_in), .wd_mode_select(wd_mode_select),
	.window_ratio_sel_lo(window_ratio_sel_lo),
	.window_ratio_sel_hi(window_ratio_sel_hi),
	.rst_period_setting(rst_period_setting),
	.wd_period_setting(wd_period_setting), .rst_n(rst_n), .wdFault(wdFault));

//--- test/supervisor_watchdog_reset_test.sv
// bench for both watchdog variants
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
$display("[ERR] %0t %h %h", $time, a, b); end end
module supervisor_watchdog_reset_test;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] cause = 3'h0;
	logic mode = 1'b0;
	logic selLo = 1'b0;
	logic selHi = 1'b0;
	logic [31:0] wdP = 32'hc8;
	logic [15:0] gap = 16'h0;
	logic kick;
	logic [1:0] up;
	logic [1:0] flt;
	int fails = 0;
	int compares = 0;
	int fs, fw, rs, pf, pw;
	// u_dut[0] single timeout, [1] windowed with a fixed slow limit of 200
	for (genvar g = 0; g < 2; g++) begin : g_var
		svwd_top #(.WINDOWED(g == 1)) u_dut (.mclk(mclk), .reset(reset),
			.supplyLow(cause[0]), .monLevelLow(cause[1]),
			.manual_rst_n(!cause[2]), .wd_kick_in(kick),
			.wd_mode_select(mode), .window_ratio_sel_lo(selLo),
			.window_ratio_sel_hi(selHi), .rst_period_setting(32'h14),
			.wd_period_setting(g ? 32'hc8 : wdP), .rst_n(up[g]),
			.wdFault(flt[g]));
	end
	svwd_cpu_model u_cpu (.mclk(mclk), .rstN(&up), .gap(gap), .kick(kick));
	initial begin
		forever #4 mclk = ~mclk;
	end
	task automatic test_done;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// first drop of each reset, first fault pulse of each, and first
	// release of the single one after its drop
	task automatic watch(input int n);
		fs = n;
		fw = n;
		rs = n;
		pf = n;
		pw = n;
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			if (flt[0] === 1'b1 && pf == n) pf = i;
			if (flt[1] === 1'b1 && pw == n) pw = i;
			if (up[0] === 1'b1 && fs < n && rs == n) rs = i;
			if (up[0] !== 1'b1 && fs == n) fs = i;
			if (up[1] !== 1'b1 && fw == n) fw = i;
		end
	endtask
	task automatic restart(input int c);
		int n;
		n = 0;
		cause[c] = 1'b1;
		repeat (8) @(negedge mclk);
		`CHK(up, 2'b00)
		cause[c] = 1'b0;
		while (up !== 2'b11 && n < 99) begin
			@(negedge mclk);
			n++;
		end
		`CHK(n inside {[20:26]}, 1'b1)
	endtask
	task automatic t_timeout;
		restart(2);
		watch(400);
		`CHK(fs inside {[196:204]}, 1'b1)
		`CHK(fw inside {[196:204]}, 1'b1)
		`CHK(rs - fs inside {[20:22]}, 1'b1)
		`CHK(pf, fs)
		`CHK(pw, fw)
		gap = 16'h64;
		restart(2);
		watch(1000);
		`CHK(fs, 1000)
		`CHK(fw, 1000)
	endtask
	task automatic t_ratio;
		for (int i = 0; i < 6; i++) begin
			{selLo, selHi} = (i % 3 == 2) ? 2'b11 : {1'b0, i % 3 == 1};
			gap = (i < 3) ? 16'h14 : 16'ha;
			restart(2);
			watch(300);
			`CHK(fw < 300, i == 0 || i == 3 || i == 4)
			`CHK(pw, fw)
		end
		{gap, selLo, selHi} = 18'h0;
	endtask
	task automatic t_clear;
		restart(2);
		watch(150);
		{mode, selHi} = 2'b11;
		watch(4);
		{mode, selHi} = 2'b00;
		watch(400);
		`CHK(fs inside {[196:206]}, 1'b1)
		`CHK(fw inside {[196:206]}, 1'b1)
	endtask
	task automatic t_off;
		wdP = 32'h0;
		selLo = 1'b1;
		restart(1);
		watch(600);
		`CHK(fs, 600)
		`CHK(fw, 600)
		wdP = 32'hc8;
		selLo = 1'b0;
		mode = 1'b1;
		restart(0);
		watch(25700);
		`CHK(fs inside {[25596:25606]}, 1'b1)
	endtask
	initial begin
		#400000;
		fails++;
		test_done();
	end
	initial begin
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		t_timeout();
		t_ratio();
		t_clear();
		t_off();
		test_done();
	end
endmodule
